// File: hw/preset_seq_consts.svh
// Constants for the preset speed and auto-run sequencer block.
// Assumes a 20 MHz system clock and a classic Wishbone register bus.
// Functional notes
// - Ramp mode: 0 shared, 1 per preset
// - Eight preset speeds, 0.00 to 650.00 Hz
// - Per-preset accel and decel, 0.1-3600.0 s
// - Mode 0 uses global pair one or two
// - Mode 1 uses selected preset's ramp pair
// - Ramp equals time times freq over max
// - Max freq: user value if pattern 7
// - Non-continuous run ramps from zero, scaled
// - Sequencer modes: off, single, periodic, hold
// - Modes 1-3 resume unfinished step
// - Modes 4-6 restart from step zero
// - Step zero frequency from preset zero
// - Step 1-7 frequencies, 0.00-650.00 Hz
// - Step durations 0.00 to 3600.0 s
// - Direction code: 0 stop, 1 forward, 2 backward
// - Single cycle runs steps once, then stops
// - Periodic cycle repeats from step zero
// - Hold mode keeps last step running
// - Sequencer uses global ramp pairs only
`ifndef PRESET_SEQ_CONSTS_SVH
`define PRESET_SEQ_CONSTS_SVH

// ==========================================================
// Register offsets (byte addresses)
// ==========================================================
`define OFS_CTRL 8'h00
`define OFS_GLOBAL1 8'h04
`define OFS_GLOBAL2 8'h08
`define OFS_MAXF 8'h0c
`define OFS_STATUS 8'h10
`define OFS_PRESET 8'h20
`define OFS_PRESET_RAMP 8'h40
`define OFS_STEP_FREQ 8'h60
`define OFS_STEP_TIME 8'h80
`define OFS_STEP_DIR 8'ha0

// ==========================================================
// Field positions and limits
// ==========================================================
`define CTRL_RAMP_MODE 0
`define CTRL_PAIR_SEL 1
`define CTRL_VF_LO 4
`define CTRL_SEQ_LO 8
`define VF_USER 4'h7
`define FREQ_MAX 16'hfde8
`define RAMP_MIN 16'h0001
`define RAMP_MAX 16'h8ca0
`define TIME_MAX 19'h57e40
`define FREQ_50HZ 16'h1388
`define FREQ_60HZ 16'h1770
`define RESET_MAXF 16'h1770
`define RESET_RAMP 16'h0064

// ==========================================================
// Timing: step time unit is 10 ms
// ==========================================================
`define TICK_MS 10
`define CLK_KHZ 20000
`define TICK_CYCLES (`TICK_MS * `CLK_KHZ)

`endif

// File: hw/preset_seq_pkg.sv
// Types for the preset speed and auto-run sequencer block.
// Assumes the constants header is included by the design.
package preset_seq_pkg;
    // ======================================================
    // Sequencer state machine, one-hot
    // ======================================================
    typedef enum logic [3:0] {
        SEQ_IDLE = 4'b0001,
        SEQ_RUN = 4'b0010,
        SEQ_HOLD = 4'b0100,
        SEQ_DONE = 4'b1000
    } seq_state_t;

    // Step direction codes
    typedef enum logic [1:0] {
        DIR_STOP = 2'h0,
        DIR_FORWARD = 2'h1,
        DIR_BACKWARD = 2'h2
    } dir_code_t;
endpackage : preset_seq_pkg

// File: hw/preset_speed_auto_sequencer.sv
// Preset speed selection, ramp time scaling and auto-run sequencer.
// Assumes terminal inputs are asynchronous pins and registers are
// reached over classic Wishbone with one 32-bit word per register.
//
// Added by the designer: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`include "preset_seq_consts.svh"

module preset_speed_auto_sequencer
    import preset_seq_pkg::*;
#(
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic run_in,
    input wire logic [2:0] preset_sel_in,
    input wire logic seq_enable_in,
    output logic [15:0] freq_cmd,
    output logic [1:0] dir_cmd,
    output logic run_cmd,
    output logic [31:0] ramp_cycles_ms,
    output logic ramp_decel,
    output logic ramp_load
);

    // ======================================================
    // Helper functions
    // ======================================================
    // Byte-lane merge of a write into a 32-bit word
    function automatic logic [31:0] merge(input logic [31:0] old,
            input logic [31:0] wd, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // Clamp a 16-bit value into [lo, hi]
    function automatic logic [15:0] clamp16(input logic [15:0] v,
            input logic [15:0] lo, input logic [15:0] hi);
        logic [15:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction : clamp16

    // Time (0.1 s) times frequency over max, result in ms
    function automatic logic [31:0] scale(input logic [15:0] t,
            input logic [15:0] f, input logic [15:0] fmax);
        logic [47:0] p;
        p = 48'(t) * 48'(f) * 48'd100;
        if (fmax == 16'h0000) begin
            return 32'h0000_0000;
        end
        return 32'(p / 48'(fmax));
    endfunction : scale

    // ======================================================
    // Pin synchronisers
    // ======================================================
    logic [4:0] sync1_reg; // First stage, read only by stage two
    logic [4:0] sync2_reg; // Second stage, safe to use
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_reg <= 5'h00;
            sync2_reg <= 5'h00;
        end else begin
            sync1_reg <= {seq_enable_in, preset_sel_in, run_in};
            sync2_reg <= sync1_reg;
        end
    end
    logic run_s; // Synchronised run command
    logic seq_en_s; // Synchronised sequencer enable
    logic [2:0] sel_s; // Synchronised preset select
    assign run_s = sync2_reg[0];
    assign sel_s = sync2_reg[3:1];
    assign seq_en_s = sync2_reg[4];

    // ======================================================
    // Parameter storage
    // ======================================================
    logic [15:0] ctrl_reg; // Mode bits
    logic [31:0] global1_reg; // First global pair, accel low half
    logic [31:0] global2_reg; // Second global pair
    logic [15:0] maxf_reg; // User maximum frequency
    logic [15:0] preset_reg [8]; // Preset speeds, 0.01 Hz
    logic [31:0] pramp_reg [8]; // Per-preset accel/decel, 0.1 s
    logic [15:0] sfreq_reg [8]; // Step frequencies, index 0 unused
    logic [18:0] stime_reg [8]; // Step durations, 10 ms
    logic [1:0] sdir_reg [8]; // Step directions

    logic wb_hit; // Request in progress, not yet answered
    logic [2:0] idx; // Word index inside a table
    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign idx = wb_adr_i[4:2];

    // Register writes, range clamped except the control word and global pairs
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg <= 16'h0000;
            global1_reg <= {`RESET_RAMP, `RESET_RAMP};
            global2_reg <= {`RESET_RAMP, `RESET_RAMP};
            maxf_reg <= `RESET_MAXF;
            for (int i = 0; i < 8; i++) begin
                preset_reg[i] <= 16'h0000;
                pramp_reg[i] <= {`RESET_RAMP, `RESET_RAMP};
                sfreq_reg[i] <= 16'h0000;
                stime_reg[i] <= 19'h00000;
                sdir_reg[i] <= 2'h0;
            end
        end else if (wb_hit && wb_we_i) begin
            case (wb_adr_i[7:5])
                3'h0: begin
                    // Control block
                    if (wb_adr_i[4:2] == 3'h0) begin
                        ctrl_reg <= 16'(merge({16'h0000, ctrl_reg},
                            wb_dat_i, wb_sel_i));
                    end else if (wb_adr_i[4:2] == 3'h1) begin
                        global1_reg <= merge(global1_reg, wb_dat_i,
                            wb_sel_i);
                    end else if (wb_adr_i[4:2] == 3'h2) begin
                        global2_reg <= merge(global2_reg, wb_dat_i,
                            wb_sel_i);
                    end else if (wb_adr_i[4:2] == 3'h3) begin
                        maxf_reg <= clamp16(16'(merge({16'h0000,
                            maxf_reg}, wb_dat_i, wb_sel_i)), 16'h0001,
                            `FREQ_MAX);
                    end
                end
                3'h1: begin
                    // Preset speeds
                    preset_reg[idx] <= clamp16(16'(merge(
                        {16'h0000, preset_reg[idx]}, wb_dat_i,
                        wb_sel_i)), 16'h0000, `FREQ_MAX);
                end
                3'h2: begin
                    // Per-preset ramp pair, each half clamped
                    pramp_reg[idx] <= {
                        clamp16(16'(merge(pramp_reg[idx], wb_dat_i,
                            wb_sel_i) >> 16), `RAMP_MIN, `RAMP_MAX),
                        clamp16(16'(merge(pramp_reg[idx], wb_dat_i,
                            wb_sel_i)), `RAMP_MIN, `RAMP_MAX)
                    };
                end
                3'h3: begin
                    sfreq_reg[idx] <= clamp16(16'(merge(
                        {16'h0000, sfreq_reg[idx]}, wb_dat_i,
                        wb_sel_i)), 16'h0000, `FREQ_MAX);
                end
                3'h4: begin
                    // Durations beyond the limit are clamped
                    stime_reg[idx] <= (19'(merge({13'h0, stime_reg[idx]},
                        wb_dat_i, wb_sel_i)) > `TIME_MAX) ? `TIME_MAX :
                        19'(merge({13'h0, stime_reg[idx]}, wb_dat_i,
                        wb_sel_i));
                end
                3'h5: begin
                    // Code 3 is not a direction, store as stop
                    if (wb_sel_i[0]) begin
                        sdir_reg[idx] <= (wb_dat_i[1:0] == 2'h3) ?
                            2'h0 : wb_dat_i[1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ======================================================
    // Mode decode
    // ======================================================
    logic ramp_mode; // 0 shared, 1 per preset
    logic pair_sel; // 0 first pair, 1 second pair
    logic [3:0] vf_pattern; // Voltage/frequency pattern
    logic [2:0] seq_mode; // Sequencer mode 0..6
    logic [15:0] fmax; // Effective maximum frequency
    assign ramp_mode = ctrl_reg[`CTRL_RAMP_MODE];
    assign pair_sel = ctrl_reg[`CTRL_PAIR_SEL];
    assign vf_pattern = ctrl_reg[`CTRL_VF_LO +: 4];
    assign seq_mode = (ctrl_reg[`CTRL_SEQ_LO +: 3] == 3'h7) ?
        3'h0 : ctrl_reg[`CTRL_SEQ_LO +: 3];
    // Even patterns assume 50 Hz mains, odd ones other than 7 assume 60 Hz
    assign fmax = (vf_pattern == `VF_USER) ? maxf_reg :
        (vf_pattern[0] ? `FREQ_60HZ : `FREQ_50HZ);

    logic seq_single; // Modes 1 and 4
    logic seq_periodic; // Modes 2 and 5
    logic seq_resume; // Modes 1 to 3 resume
    assign seq_single = (seq_mode == 3'h1) || (seq_mode == 3'h4);
    assign seq_periodic = (seq_mode == 3'h2) || (seq_mode == 3'h5);
    assign seq_resume = (seq_mode >= 3'h1) && (seq_mode <= 3'h3);

    // ======================================================
    // Sequencer
    // ======================================================
    seq_state_t state_reg; // Sequencer state
    logic [2:0] step_reg; // Current step
    logic [18:0] left_reg; // Ticks left in current step
    logic [17:0] tick_cnt_reg; // 10 ms prescaler
    logic tick; // One pulse each 10 ms
    logic seq_go; // Sequencer allowed to run
    logic [2:0] next_step; // Next used step after current
    logic wrap; // Next step search wrapped past 7
    assign seq_go = run_s && seq_en_s && (seq_mode != 3'h0);
    assign tick = (tick_cnt_reg == 18'(TICK_CYCLES - 1));

    // Find next step with nonzero duration
    always_comb begin
        next_step = step_reg;
        wrap = 1'b1;
        for (int k = 7; k >= 1; k--) begin
            if ((32'(step_reg) + 32'(k) <= 32'd7) &&
                    (stime_reg[3'(32'(step_reg) + 32'(k))] != 19'h0)) begin
                next_step = 3'(32'(step_reg) + 32'(k));
                wrap = 1'b0;
            end
        end
    end

    // Prescaler for step timing
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_cnt_reg <= 18'h00000;
        end else if (tick || state_reg != SEQ_RUN) begin
            tick_cnt_reg <= 18'h00000;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 18'h00001;
        end
    end

    // Sequencer state, step and time left
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= SEQ_IDLE;
            step_reg <= 3'h0;
            left_reg <= 19'h00000;
        end else if (!seq_go) begin
            // Stop: resume modes keep step and time left unless in hold or done
            if (state_reg != SEQ_IDLE) begin
                state_reg <= SEQ_IDLE;
            end
            if (!seq_resume || state_reg == SEQ_DONE ||
                    state_reg == SEQ_HOLD) begin
                step_reg <= 3'h0;
                left_reg <= 19'h00000;
            end
        end else begin
            case (state_reg)
                SEQ_IDLE: begin
                    state_reg <= SEQ_RUN;
                    if (left_reg == 19'h0) begin
                        // Fresh start at step 0 or resumed step
                        left_reg <= stime_reg[step_reg];
                    end
                end
                SEQ_RUN: begin
                    if (left_reg == 19'h0 || (tick && left_reg == 19'h1))
                    begin
                        if (!wrap) begin
                            step_reg <= next_step;
                            left_reg <= stime_reg[next_step];
                        end else if (seq_periodic) begin
                            step_reg <= 3'h0;
                            left_reg <= stime_reg[0];
                        end else if (seq_single) begin
                            state_reg <= SEQ_DONE;
                        end else begin
                            state_reg <= SEQ_HOLD;
                        end
                    end else if (tick) begin
                        left_reg <= left_reg - 19'h00001;
                    end
                end
                SEQ_HOLD, SEQ_DONE: begin
                    // Parked until enable or run drops
                    state_reg <= state_reg;
                end
                default: begin
                    state_reg <= SEQ_IDLE;
                end
            endcase
        end
    end

    // ======================================================
    // Frequency and ramp selection
    // ======================================================
    logic seq_active; // Sequencer drives output
    logic [15:0] target_f; // Target frequency
    logic [1:0] target_dir; // Target direction
    logic target_run; // Output enabled
    logic [2:0] ramp_idx; // Preset whose ramp pair is used
    logic [31:0] pair; // Chosen ramp pair {decel, accel}
    logic [15:0] prev_f_reg; // Last target, for continuous moves
    logic prev_run_reg; // Last run state
    logic [15:0] delta_f; // Frequency change to ramp over
    logic going_down; // Ramp decelerates

    assign seq_active = seq_go;
    // Step 0 uses preset speed 0
    assign target_f = !seq_active ? preset_reg[sel_s] :
        (step_reg == 3'h0 ? preset_reg[0] : sfreq_reg[step_reg]);
    assign target_dir = seq_active ? sdir_reg[step_reg] : 2'(DIR_FORWARD);
    assign target_run = seq_active ? (state_reg != SEQ_DONE &&
        target_dir != 2'(DIR_STOP)) : run_s;
    assign ramp_idx = sel_s;
    // Sequencer always uses a global pair
    assign pair = (ramp_mode && !seq_active) ? pramp_reg[ramp_idx] :
        (pair_sel ? global2_reg : global1_reg);
    assign going_down = prev_run_reg && (target_f < prev_f_reg);
    // Continuous moves ramp only the difference
    assign delta_f = !prev_run_reg ? target_f :
        (going_down ? prev_f_reg - target_f : target_f - prev_f_reg);

    // Output registers: frequency and ramp reloaded on start, stop or a change of target frequency while running; run and direction follow every cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            freq_cmd <= 16'h0000;
            dir_cmd <= 2'h0;
            run_cmd <= 1'b0;
            ramp_cycles_ms <= 32'h0000_0000;
            ramp_decel <= 1'b0;
            ramp_load <= 1'b0;
            prev_f_reg <= 16'h0000;
            prev_run_reg <= 1'b0;
        end else begin
            ramp_load <= 1'b0;
            if (target_run && (!prev_run_reg ||
                    target_f != prev_f_reg)) begin
                freq_cmd <= target_f;
                ramp_decel <= going_down;
                ramp_cycles_ms <= scale(going_down ? pair[31:16] :
                    pair[15:0], delta_f, fmax);
                ramp_load <= 1'b1;
                prev_f_reg <= target_f;
            end else if (!target_run && prev_run_reg) begin
                freq_cmd <= 16'h0000;
                ramp_decel <= 1'b1;
                ramp_cycles_ms <= scale(pair[31:16], prev_f_reg, fmax);
                ramp_load <= 1'b1;
                prev_f_reg <= 16'h0000;
            end
            prev_run_reg <= target_run;
            run_cmd <= target_run;
            dir_cmd <= target_run ? target_dir : 2'h0;
        end
    end

    // ======================================================
    // Wishbone read and acknowledge
    // ======================================================
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= 32'h0000_0000;
            if (wb_hit && !wb_we_i) begin
                case (wb_adr_i[7:5])
                    3'h0: begin
                        case (wb_adr_i[4:2])
                            3'h0: wb_dat_o <= {16'h0000, ctrl_reg};
                            3'h1: wb_dat_o <= global1_reg;
                            3'h2: wb_dat_o <= global2_reg;
                            3'h3: wb_dat_o <= {16'h0000, maxf_reg};
                            3'h4: wb_dat_o <= {state_reg, 1'b0, step_reg,
                                5'h00, left_reg};
                            default: wb_dat_o <= 32'h0000_0000;
                        endcase
                    end
                    3'h1: wb_dat_o <= {16'h0000, preset_reg[idx]};
                    3'h2: wb_dat_o <= pramp_reg[idx];
                    3'h3: wb_dat_o <= {16'h0000, sfreq_reg[idx]};
                    3'h4: wb_dat_o <= {13'h0000, stime_reg[idx]};
                    3'h5: wb_dat_o <= {30'h0, sdir_reg[idx]};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule : preset_speed_auto_sequencer

// File: verification/seq_props.sv
// Port checker for the preset speed and sequencer block.
// Assumes it is bound to the top module, one clock domain.
`timescale 1ns/1ps
module seq_props #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [15:0] freq_cmd,
    input wire logic [1:0] dir_cmd,
    input wire logic run_cmd,
    input wire logic [31:0] ramp_cycles_ms,
    input wire logic ramp_load
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // ==========================================================
    // Bus handshake
    // ==========================================================
    a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("ack late");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_ack_no_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    // ==========================================================
    // Command outputs
    // ==========================================================
    a_dir_legal: assert property (dir_cmd != 2'h3)
        else $error("bad direction");
    a_freq_limit: assert property (freq_cmd <= 16'hfde8)
        else $error("frequency too high");
    a_load_pulse: assert property (ramp_load |=> !ramp_load)
        else $error("load not a pulse");
    a_ramp_tied: assert property ($changed(ramp_cycles_ms)
        |-> ramp_load || $past(ramp_load)) else $error("ramp without load");
    a_reset_quiet: assert property ($rose(reset_n)
        |-> !run_cmd && freq_cmd == 16'h0) else $error("busy after reset");
    c_load: cover property (ramp_load);
    c_reverse: cover property (run_cmd && dir_cmd == 2'h2);
    c_bus: cover property (wb_ack_o);
endmodule : seq_props

bind preset_speed_auto_sequencer seq_props #(.TICK_CYCLES(TICK_CYCLES))
    props_u (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .freq_cmd(freq_cmd),
    .dir_cmd(dir_cmd), .run_cmd(run_cmd), .ramp_cycles_ms(ramp_cycles_ms),
    .ramp_load(ramp_load));

// File: verification/ramp_gen_model.sv
// Far-side ramp generator model: latches each new command.
// Assumes the command settles within one cycle of the load pulse.
`timescale 1ns/1ps
module ramp_gen_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ramp_load,
    input wire logic [15:0] freq_cmd,
    input wire logic [31:0] ramp_cycles_ms,
    input wire logic ramp_decel,
    output logic [15:0] last_freq,
    output logic [31:0] last_ms,
    output logic last_decel
);
    logic load_seen; // Load pulse one cycle late
    // Latch late, so either output timing is read correctly
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            load_seen <= 1'b0;
            last_freq <= 16'h0;
            last_ms <= 32'h0;
            last_decel <= 1'b0;
        end else begin
            load_seen <= ramp_load;
            if (load_seen) begin
                last_freq <= freq_cmd;
                last_ms <= ramp_cycles_ms;
                last_decel <= ramp_decel;
            end
        end
    end
endmodule : ramp_gen_model

// File: verification/preset_speed_auto_sequencer_test.sv
// Self-checking bench for the preset speed and sequencer block.
// Assumes a short step tick so sequences finish quickly.
`timescale 1ns/1ps
module preset_speed_auto_sequencer_test;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, run = 1'b0, sen = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [2:0] psel = 3'h0;
    logic [31:0] wdat = 32'h0, rdat, q, ms, pms;
    logic [15:0] freq, pf;
    logic [1:0] dir;
    logic runc, dec, ld, pdec;
    int n_errors = 0, check_count = 0;
    preset_speed_auto_sequencer #(.TICK_CYCLES(4)) dut_u (.clk(clk),
        .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .run_in(run), .preset_sel_in(psel),
        .seq_enable_in(sen), .freq_cmd(freq), .dir_cmd(dir), .run_cmd(runc),
        .ramp_cycles_ms(ms), .ramp_decel(dec), .ramp_load(ld));
    ramp_gen_model far_u (.clk(clk), .reset_n(reset_n), .ramp_load(ld),
        .freq_cmd(freq), .ramp_cycles_ms(ms), .ramp_decel(dec),
        .last_freq(pf), .last_ms(pms), .last_decel(pdec));
    initial begin
        forever #25 clk = ~clk;
    end
    task finish_test;
        $display("Checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : finish_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // Waits spent to their bound count as a mismatch
    task give_up(input int i);
        if (i >= 200) begin
            n_errors++;
            finish_test();
        end
    endtask : give_up
    // One classic Wishbone cycle, held until ack is sampled
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        {cyc, stb, we, adr, wdat, sel} <= {2'h3, w, a, d, 4'hf};
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (ack !== 1'b1 && i < 200);
        q = rdat;
        {cyc, stb, we} <= 3'h0;
        give_up(i);
    endtask : wb
    task rst;
        @(posedge clk) reset_n <= 1'b0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
    endtask : rst
    task wait_f(input logic [15:0] f, input logic [1:0] d);
        int i;
        i = 0;
        while ((freq !== f || dir !== d) && i < 200) begin
            @(posedge clk);
            i++;
        end
        give_up(i);
    endtask : wait_f
    // Start or retarget, then judge the command the far side took
    task ramp(input logic [31:0] c, input logic [2:0] s, input logic [31:0]
        ems, input logic edec, input logic [15:0] ef);
        int i;
        wb(1'b1, 8'h00, c);
        {psel, run} <= {s, 1'b1};
        i = 0;
        while (ld !== 1'b1 && i < 200) begin
            @(posedge clk);
            i++;
        end
        give_up(i);
        repeat (2) @(posedge clk);
        chk({pdec, pf, pms[14:0]}, {edec, ef, ems[14:0]});
    endtask : ramp
    task stop;
        @(posedge clk) run <= 1'b0;
        repeat (20) @(posedge clk);
    endtask : stop
    // Two-step program: step 0 at 15 Hz forward, step 1 at 20 Hz reverse
    task seq(input logic [2:0] m);
        int i;
        rst();
        wb(1'b1, 8'h20, 32'h5dc);
        wb(1'b1, 8'h64, 32'h7d0);
        wb(1'b1, 8'h80, 32'h2);
        wb(1'b1, 8'h84, 32'h2);
        wb(1'b1, 8'ha0, 32'h1);
        wb(1'b1, 8'ha4, 32'h2);
        wb(1'b1, 8'h04, 32'h000a000a);
        wb(1'b1, 8'h40, 32'h00630063);
        wb(1'b1, 8'h00, {21'h0, m, 8'h71});
        {sen, run} <= 2'h3;
        wait_f(16'h5dc, 2'h1);
        repeat (2) @(posedge clk);
        chk(pms, 32'hfa);
        wait_f(16'h7d0, 2'h2);
        // Stop inside step 1, then restart: resume or begin anew
        run <= 1'b0;
        repeat (4) @(posedge clk);
        run <= 1'b1;
        i = 0;
        while (freq === 16'h0 && i < 200) begin
            @(posedge clk);
            i++;
        end
        chk(freq, (m < 3'h4) ? 32'h7d0 : 32'h5dc);
        wait_f(16'h7d0, 2'h2);
        i = 0;
        if (m == 3'h1 || m == 3'h4) begin
            while (runc !== 1'b0 && i < 200) begin
                @(posedge clk);
                i++;
            end
            chk(i < 200, 1'b1);
        end else if (m == 3'h2 || m == 3'h5) begin
            wait_f(16'h5dc, 2'h1);
            repeat (2) @(posedge clk);
            chk({pdec, pms[30:0]}, {1'b1, 31'h53});
        end else begin
            repeat (40) @(posedge clk);
            chk({runc, dir, freq}, {1'b1, 2'h2, 16'h7d0});
        end
        {sen, run} <= 2'h0;
    endtask : seq
    initial begin
        rst();
        wb(1'b0, 8'h0c, 32'h0);
        chk(q, 32'h1770);
        wb(1'b1, 8'hfc, 32'h5a5a5a5a);
        wb(1'b0, 8'hfc, 32'h0);
        chk(q, 32'h0);
        wb(1'b1, 8'h0c, 32'h1388);
        wb(1'b1, 8'h24, 32'h3e8);
        wb(1'b1, 8'h44, {16'hc8, 16'h32});
        wb(1'b1, 8'h28, 32'h1f4);
        wb(1'b1, 8'h48, {16'h50, 16'h1e});
        wb(1'b1, 8'h04, {16'h28, 16'h1e});
        wb(1'b1, 8'h08, {16'h28, 16'h2d});
        ramp(32'h71, 3'h1, 32'h3e8, 1'b0, 16'h3e8);
        ramp(32'h71, 3'h2, 32'h320, 1'b1, 16'h1f4);
        stop();
        ramp(32'h10, 3'h1, 32'h1f4, 1'b0, 16'h3e8);
        stop();
        ramp(32'h02, 3'h1, 32'h384, 1'b0, 16'h3e8);
        stop();
        for (int k = 1; k < 7; k++) seq(k[2:0]);
        finish_test();
    end
endmodule : preset_speed_auto_sequencer_test
